/* prog_link_access_layer.sv */
// Access layer of a half-duplex serial programming link, with its character engine.
// Assumes a push-pull pin with pull-up outside, resolved from o_link_data_oe, and a
// system-side memory that answers each request with a one-cycle i_mem_ack.
// Functional notes
// - Message starts with programmer instruction byte.
// - Read messages answered with one device byte.
// - Stores and writes take one operand; key takes eight.
// - Access layer commands receive or transmit.
// - Parity, frame, break while receiving: exception.
// - Collision while transmitting is an exception.
// - Exception aborts transfer, enters error state.
// - Error state left only by BREAK.
// - Indirect load, optional pointer post-increment.
// - Indirect store, optional pointer post-increment.
// - Pointer byte store, low opcode bit selects.
// - I/O read at six-bit opcode address.
// - I/O write at six-bit opcode address.
// - Control/status read at four-bit address.
// - Control/status write at four-bit address.
// - Eight key bytes compared with enable key.
// - Each instruction is one character byte.
// - Start, eight LSB-first bits, even parity, two stops.
// - BREAK is twelve or more low bits.
// - Guard idle bits plus two before transmit.
`timescale 1ns/100ps
`default_nettype none
module prog_link_access_layer #(
   parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value.
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_link_clock,
   input  wire logic        i_link_data,
   output var  logic        o_link_data,
   output var  logic        o_link_data_oe,
   output var  logic        o_mem_req,
   output var  logic        o_mem_write,
   output var  logic        o_mem_io,
   output var  logic [15:0] o_mem_addr,
   output var  logic [7:0]  o_mem_wdata,
   input  wire logic        i_mem_ack,
   input  wire logic [7:0]  i_mem_rdata,
   output var  logic        o_nvm_enable,
   output var  logic        o_link_error
);
   import prog_link_pkg::*;

   typedef enum logic [2:0] {st_idle, st_operand, st_wait_mem, st_send, st_error} state_t;

   state_t      state_q;
   cmd_t        cmd_q;
   cmd_t        cmd_now;
   logic [7:0]  op_q;
   logic [1:0]  din_sync_q;
   logic        din;
   logic        rx_active_q, rx_wait_high_q, rx_valid_q, rx_break_q, rx_err_q;
   logic [3:0]  rx_cnt_q;
   logic [10:0] rx_shift_q;
   logic [10:0] rx_full;
   logic [7:0]  rx_data_q;
   logic        tx_mode, tx_go_q, tx_busy_q, tx_send_q, tx_prev_q, tx_done_q;
   logic [7:0]  tx_byte_q, tx_guard_q;
   logic [3:0]  tx_cnt_q;
   logic [11:0] tx_shift_q;
   logic [1:0]  chk_q;
   logic        collision, exception;
   logic [2:0]  key_cnt_q;
   logic [63:0] key_q;
   logic [15:0] ptr_q;
   logic        nvm_en_q;
   logic [2:0]  guard_q;
   logic        rd_issue, wr_issue, operand_taken;
   logic        req_tgl_q, req_write_q, req_io_q;
   logic [15:0] req_addr_q;
   logic [7:0]  req_wdata_q;
   logic [2:0]  ack_sync_q;
   logic        ack_edge;
   logic [2:0]  req_sync_q;
   logic        ack_tgl_q;
   logic        pend_q;
   logic [7:0]  rdata_q;
   logic [1:0]  nvm_sync_q, err_sync_q;

   function automatic logic [7:0] css_read(input logic [3:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == CSS_STATUS) begin
         v[STATUS_NVM] = nvm_en_q;
      end else if (a == CSS_PHY_CTRL) begin
         v = {5'h00, guard_q};
      end else if (a == CSS_IDENT) begin
         v = IDENT_CODE;
      end
      return v;
   endfunction : css_read

   // ---------------- Link clock domain ----------------
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         din_sync_q <= 2'b11;
      end else begin
         din_sync_q <= {din_sync_q[0], i_link_data};
      end
   end
   assign din     = din_sync_q[1];
   assign rx_full = {din, rx_shift_q[10:1]};

   // Receiver: after a BREAK it waits for the line to rise, so a long BREAK counts once.
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         rx_active_q    <= 1'b0;
         rx_wait_high_q <= 1'b0;
         rx_cnt_q       <= 4'h0;
         rx_shift_q     <= 11'h000;
         rx_data_q      <= 8'h00;
         rx_valid_q     <= 1'b0;
         rx_break_q     <= 1'b0;
         rx_err_q       <= 1'b0;
      end else begin
         rx_valid_q <= 1'b0;
         rx_break_q <= 1'b0;
         rx_err_q   <= 1'b0;
         if (tx_mode) begin
            rx_active_q    <= 1'b0;
            rx_wait_high_q <= 1'b1;
         end else if (rx_wait_high_q) begin
            rx_wait_high_q <= ~din;
         end else if (!rx_active_q) begin
            rx_active_q <= ~din;
            rx_cnt_q    <= 4'h0;
         end else begin
            rx_shift_q <= rx_full;
            rx_cnt_q   <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'(FRAME_BITS - 2)) begin
               rx_active_q <= 1'b0;
               if (rx_full == 11'h000) begin
                  rx_break_q     <= 1'b1;
                  rx_wait_high_q <= 1'b1;
               end else if (rx_full[10:9] != 2'b11 || rx_full[8] != ^rx_full[7:0]) begin
                  rx_err_q <= 1'b1;
               end else begin
                  rx_valid_q <= 1'b1;
                  rx_data_q  <= rx_full[7:0];
               end
            end
         end
      end
   end

   assign tx_mode = (state_q == st_send);

   // Transmitter: a one is driven only in its first cycle, then left to the pull-up.
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         tx_busy_q      <= 1'b0;
         tx_send_q      <= 1'b0;
         tx_prev_q      <= 1'b1;
         tx_done_q      <= 1'b0;
         tx_guard_q     <= 8'h00;
         tx_cnt_q       <= 4'h0;
         tx_shift_q     <= 12'hFFF;
         o_link_data    <= 1'b1;
         o_link_data_oe <= 1'b0;
      end else begin
         tx_done_q <= 1'b0;
         if (collision || !tx_mode) begin
            tx_busy_q      <= 1'b0;
            tx_send_q      <= 1'b0;
            o_link_data    <= 1'b1;
            o_link_data_oe <= 1'b0;
         end else if (tx_go_q) begin
            tx_busy_q  <= 1'b1;
            tx_guard_q <= guard_bits(guard_q) + 8'(MIN_IDLE);
            tx_cnt_q   <= 4'h0;
            tx_shift_q <= {2'b11, ^tx_byte_q, tx_byte_q, 1'b0};
            tx_prev_q  <= 1'b1;
         end else if (tx_busy_q) begin
            if (tx_guard_q != 8'h00) begin
               tx_guard_q <= tx_guard_q - 8'h01;
            end else if (tx_cnt_q < 4'(FRAME_BITS)) begin
               o_link_data    <= tx_shift_q[0];
               o_link_data_oe <= ~tx_shift_q[0] | ~tx_prev_q;
               tx_prev_q      <= tx_shift_q[0];
               tx_shift_q     <= {1'b1, tx_shift_q[11:1]};
               tx_cnt_q       <= tx_cnt_q + 4'h1;
               tx_send_q      <= 1'b1;
            end else if (tx_cnt_q < 4'(FRAME_BITS + SYNC_LAT)) begin
               // Trailing cycles let the released stop bits be checked for collision.
               o_link_data    <= 1'b1;
               o_link_data_oe <= 1'b0;
               tx_send_q      <= 1'b0;
               tx_cnt_q       <= tx_cnt_q + 4'h1;
            end else begin
               tx_busy_q <= 1'b0;
               tx_done_q <= 1'b1;
            end
         end
      end
   end

   // The sampled line lags the pin by the synchroniser depth, so the check is delayed too.
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         chk_q <= 2'b00;
      end else begin
         chk_q <= {chk_q[0], tx_send_q & ~o_link_data_oe & tx_mode};
      end
   end
   assign collision = chk_q[1] & ~din & tx_mode;
   assign exception = rx_break_q | rx_err_q | collision;

   assign cmd_now       = decode_op(rx_data_q);
   assign operand_taken = (state_q == st_operand) && rx_valid_q;
   assign rd_issue      = (state_q == st_idle) && rx_valid_q &&
                          (cmd_now == cmd_serial_load_indirect || cmd_now == cmd_serial_io_read);
   assign wr_issue      = operand_taken &&
                          (cmd_q == cmd_serial_store_indirect || cmd_q == cmd_serial_io_write);
   assign ack_edge      = ack_sync_q[2] ^ ack_sync_q[1];

   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q   <= st_idle;
         cmd_q     <= cmd_bad;
         op_q      <= 8'h00;
         key_cnt_q <= 3'h0;
         tx_byte_q <= 8'h00;
         tx_go_q   <= 1'b0;
      end else begin
         tx_go_q <= 1'b0;
         if (exception && state_q != st_error) begin
            state_q <= st_error;
         end else begin
            case (state_q)
               st_idle: begin
                  if (rx_valid_q) begin
                     cmd_q     <= cmd_now;
                     op_q      <= rx_data_q;
                     key_cnt_q <= 3'h0;
                     if (cmd_now == cmd_bad) begin
                        state_q <= st_error;
                     end else if (rd_issue) begin
                        state_q <= st_wait_mem;
                     end else if (cmd_now == cmd_serial_ctrl_status_read) begin
                        tx_byte_q <= css_read(rx_data_q[3:0]);
                        tx_go_q   <= 1'b1;
                        state_q   <= st_send;
                     end else begin
                        state_q <= st_operand;
                     end
                  end
               end
               st_operand: begin
                  if (rx_valid_q) begin
                     key_cnt_q <= key_cnt_q + 3'h1;
                     if (cmd_q != cmd_serial_key_signal || key_cnt_q == 3'(KEY_BYTES - 1)) begin
                        state_q <= st_idle;
                     end
                  end
               end
               st_wait_mem: begin
                  if (ack_edge) begin
                     tx_byte_q <= rdata_q;
                     tx_go_q   <= 1'b1;
                     state_q   <= st_send;
                  end
               end
               st_send: begin
                  if (tx_done_q) begin
                     state_q <= st_idle;
                  end
               end
               st_error: begin
                  if (rx_break_q) begin
                     state_q <= st_idle;
                  end
               end
               default: state_q <= st_idle;
            endcase
         end
      end
   end

   // Pointer register; the programmer is trusted to have loaded it first.
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         ptr_q <= 16'h0000;
      end else if (operand_taken && cmd_q == cmd_serial_store_pointer) begin
         if (op_q[0]) begin
            ptr_q[15:8] <= rx_data_q;
         end else begin
            ptr_q[7:0] <= rx_data_q;
         end
      end else if (!exception && ((operand_taken && cmd_q == cmd_serial_store_indirect) ||
                   (state_q == st_wait_mem && ack_edge && cmd_q == cmd_serial_load_indirect))
                   && (op_q & OP_POSTINC) != 8'h00) begin
         ptr_q <= ptr_q + 16'h0001;
      end
   end

   // Control/status space and key check.
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         nvm_en_q <= 1'b0;
         guard_q  <= GUARD_RESET;
         key_q    <= 64'h0000_0000_0000_0000;
      end else if (operand_taken && cmd_q == cmd_serial_key_signal) begin
         key_q <= {key_q[55:0], rx_data_q};
         if (key_cnt_q == 3'(KEY_BYTES - 1) && {key_q[55:0], rx_data_q} == NVM_KEY) begin
            nvm_en_q <= 1'b1;
         end
      end else if (operand_taken && cmd_q == cmd_serial_ctrl_status_write) begin
         if (op_q[3:0] == CSS_STATUS) begin
            nvm_en_q <= nvm_en_q & rx_data_q[STATUS_NVM];
         end else if (op_q[3:0] == CSS_PHY_CTRL) begin
            guard_q <= rx_data_q[2:0];
         end
      end
   end

   // Memory request towards the system clock, passed by toggle.
   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         req_tgl_q   <= 1'b0;
         req_write_q <= 1'b0;
         req_io_q    <= 1'b0;
         req_addr_q  <= 16'h0000;
         req_wdata_q <= 8'h00;
      end else if (rd_issue) begin
         req_tgl_q   <= ~req_tgl_q;
         req_write_q <= 1'b0;
         req_io_q    <= (cmd_now == cmd_serial_io_read);
         req_addr_q  <= (cmd_now == cmd_serial_io_read) ? io_addr(rx_data_q) : ptr_q;
      end else if (wr_issue) begin
         req_tgl_q   <= ~req_tgl_q;
         req_write_q <= 1'b1;
         req_io_q    <= (cmd_q == cmd_serial_io_write);
         req_addr_q  <= (cmd_q == cmd_serial_io_write) ? io_addr(op_q) : ptr_q;
         req_wdata_q <= rx_data_q;
      end
   end

   always_ff @(posedge i_link_clock or posedge i_rst) begin
      if (i_rst) begin
         ack_sync_q <= 3'h0;
      end else begin
         ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
      end
   end

   // ---------------- System clock domain ----------------
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         req_sync_q <= 3'h0;
         nvm_sync_q <= 2'b00;
         err_sync_q <= 2'b00;
      end else begin
         req_sync_q <= {req_sync_q[1:0], req_tgl_q};
         nvm_sync_q <= {nvm_sync_q[0], nvm_en_q};
         err_sync_q <= {err_sync_q[0], state_q == st_error};
      end
   end
   assign o_nvm_enable = nvm_sync_q[1];
   assign o_link_error = err_sync_q[1];

   // Request fields are stable on the link side until the answer returns.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_mem_req   <= 1'b0;
         o_mem_write <= 1'b0;
         o_mem_io    <= 1'b0;
         o_mem_addr  <= 16'h0000;
         o_mem_wdata <= 8'h00;
         pend_q      <= 1'b0;
         ack_tgl_q   <= 1'b0;
         rdata_q     <= 8'h00;
      end else begin
         o_mem_req <= 1'b0;
         if (req_sync_q[2] ^ req_sync_q[1]) begin
            o_mem_req   <= 1'b1;
            o_mem_write <= req_write_q;
            o_mem_io    <= req_io_q;
            o_mem_addr  <= req_addr_q;
            o_mem_wdata <= req_wdata_q;
            pend_q      <= 1'b1;
         end else if (pend_q && i_mem_ack) begin
            rdata_q   <= i_mem_rdata;
            ack_tgl_q <= ~ack_tgl_q;
            pend_q    <= 1'b0;
         end
      end
   end

endmodule : prog_link_access_layer
`default_nettype wire

/* prog_link_pkg.sv */
// Constants, opcode patterns and decode helpers for the programming-link access layer.
// Assumes one link character carries one byte and the bit engine runs on the link clock.
package prog_link_pkg;

   localparam int unsigned FRAME_BITS = 12;
   localparam int unsigned MIN_IDLE   = 2;
   localparam int unsigned GUARD_BASE = 128;
   localparam int unsigned SYNC_LAT   = 2;
   localparam int unsigned KEY_BYTES  = 8;

   localparam logic [7:0]  OP_LOAD_IND   = 8'h20;
   localparam logic [7:0]  OP_STORE_IND  = 8'h60;
   localparam logic [7:0]  OP_POSTINC    = 8'h04;
   localparam logic [7:0]  OP_PTR_MASK   = 8'hFE;
   localparam logic [7:0]  OP_STORE_PTR  = 8'h68;
   localparam logic [7:0]  OP_IO_MASK    = 8'h90;
   localparam logic [7:0]  OP_IO_READ    = 8'h10;
   localparam logic [7:0]  OP_IO_WRITE   = 8'h90;
   localparam logic [7:0]  OP_CS_MASK    = 8'hF0;
   localparam logic [7:0]  OP_CS_READ    = 8'h80;
   localparam logic [7:0]  OP_CS_WRITE   = 8'hC0;
   localparam logic [7:0]  OP_KEY        = 8'hE0;

   localparam logic [3:0]  CSS_STATUS    = 4'h0;
   localparam logic [3:0]  CSS_PHY_CTRL  = 4'h2;
   localparam logic [3:0]  CSS_IDENT     = 4'hF;
   localparam int unsigned STATUS_NVM    = 1;
   localparam logic [2:0]  GUARD_RESET   = 3'h0;
   localparam logic [63:0] NVM_KEY       = 64'h1289_AB45_CDD8_88FF;

   typedef enum logic [3:0] {
      cmd_serial_load_indirect,
      cmd_serial_store_indirect,
      cmd_serial_store_pointer,
      cmd_serial_io_read,
      cmd_serial_io_write,
      cmd_serial_ctrl_status_read,
      cmd_serial_ctrl_status_write,
      cmd_serial_key_signal,
      cmd_bad
   } cmd_t;

   function automatic cmd_t decode_op(input logic [7:0] op);
      cmd_t c;
      c = cmd_bad;
      if ((op & ~OP_POSTINC) == OP_LOAD_IND) begin
         c = cmd_serial_load_indirect;
      end else if ((op & ~OP_POSTINC) == OP_STORE_IND) begin
         c = cmd_serial_store_indirect;
      end else if ((op & OP_PTR_MASK) == OP_STORE_PTR) begin
         c = cmd_serial_store_pointer;
      end else if ((op & OP_IO_MASK) == OP_IO_READ) begin
         c = cmd_serial_io_read;
      end else if ((op & OP_IO_MASK) == OP_IO_WRITE) begin
         c = cmd_serial_io_write;
      end else if ((op & OP_CS_MASK) == OP_CS_READ) begin
         c = cmd_serial_ctrl_status_read;
      end else if ((op & OP_CS_MASK) == OP_CS_WRITE) begin
         c = cmd_serial_ctrl_status_write;
      end else if (op == OP_KEY) begin
         c = cmd_serial_key_signal;
      end
      return c;
   endfunction : decode_op

   function automatic logic [15:0] io_addr(input logic [7:0] op);
      return {10'h000, op[6:5], op[3:0]};
   endfunction : io_addr

   function automatic logic [7:0] guard_bits(input logic [2:0] gt);
      logic [7:0] g;
      g = (gt == 3'h7) ? 8'h00 : 8'(GUARD_BASE >> gt);
      return g;
   endfunction : guard_bits

endpackage : prog_link_pkg

/* prog_link_checker_asserts.sv */
// Port assertions for the access layer, both clock domains.
// Assumes the bind below reaches every instance.
`timescale 1ns/100ps
`default_nettype none
module prog_link_checker (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_link_clock,
   input wire logic        o_link_data,
   input wire logic        o_link_data_oe,
   input wire logic        o_mem_req,
   input wire logic        o_mem_write,
   input wire logic        o_mem_io,
   input wire logic [15:0] o_mem_addr,
   input wire logic [7:0]  o_mem_wdata,
   input wire logic        o_nvm_enable,
   input wire logic        o_link_error
);
   // Each request is followed by at least eight system clock cycles without one.
   a_req_spacing: assert property (
      @(posedge i_clock) disable iff (i_rst) o_mem_req |=> (!o_mem_req) [*8])
      else $error("requests too close");
   a_fields_hold: assert property (
      @(posedge i_clock) disable iff (i_rst) !o_mem_req |-> $stable(o_mem_addr)
         && $stable(o_mem_wdata) && $stable(o_mem_write) && $stable(o_mem_io))
      else $error("fields moved without request");
   a_io_range: assert property (
      @(posedge i_clock) disable iff (i_rst) o_mem_req && o_mem_io |-> o_mem_addr[15:6] == 10'h000)
      else $error("io address beyond six bits");
   a_err_no_req: assert property (
      @(posedge i_clock) disable iff (i_rst) o_link_error |-> !o_mem_req)
      else $error("request in error state");
   a_err_nvm_hold: assert property (
      @(posedge i_clock) disable iff (i_rst) o_link_error && $past(o_link_error) |-> $stable(o_nvm_enable))
      else $error("nvm enable moved in error state");
   a_err_silent: assert property (
      @(posedge i_clock) disable iff (i_rst) o_link_error [*8] |-> !o_link_data_oe)
      else $error("wire driven in error state");
   a_zero_driven: assert property (
      @(posedge i_link_clock) disable iff (i_rst) !o_link_data |-> o_link_data_oe)
      else $error("zero bit not actively driven");
   // Released repeated ones let collisions be seen.
   a_ones_release: assert property (
      @(posedge i_link_clock) disable iff (i_rst) o_link_data && $past(o_link_data) |-> !o_link_data_oe)
      else $error("repeated one still driven");
endmodule : prog_link_checker
bind prog_link_access_layer prog_link_checker u_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_link_clock(i_link_clock), .o_link_data(o_link_data),
   .o_link_data_oe(o_link_data_oe), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
   .o_mem_io(o_mem_io), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
   .o_nvm_enable(o_nvm_enable), .o_link_error(o_link_error));
`default_nettype wire

/* prog_link_model.sv */
// Programmer model: makes the link clock, drives the shared wire.
// Assumes a bench pull-up; the clock stands still between calls.
`timescale 1ns/100ps
`default_nettype none
module prog_link_model (
   output var  logic o_link_clock,
   output var  logic o_drive,
   output var  logic o_val,
   input  wire logic i_wire
);
   initial {o_link_clock, o_drive, o_val} = 3'h1;
   // Data moves while the clock is low; the wire is sampled before the rise.
   task automatic cyc(input logic drv, input logic val, output logic smp);
      o_drive = drv;
      o_val = val;
      #6;
      smp = i_wire;
      o_link_clock = 1'b1;
      #6;
      o_link_clock = 1'b0;
   endtask : cyc
   task automatic idle(input int n);
      logic s;
      repeat (n) cyc(1'b0, 1'b1, s);
   endtask : idle
   task automatic send_bits(input logic [11:0] f);
      logic s;
      for (int i = 0; i < 12; i++) cyc(1'b1, f[i], s);
   endtask : send_bits
   task automatic send_char(input logic [7:0] b);
      send_bits({2'b11, ^b, b, 1'b0});
   endtask : send_char
   task automatic send_break();
      logic s;
      repeat (13) cyc(1'b1, 1'b0, s);
      idle(3);
   endtask : send_break
   // Stays released until the start bit, then takes the whole frame.
   task automatic recv(input logic collide, output logic [7:0] d, output int gap, output logic ok);
      logic s, p, s1, s2;
      d = 8'h00;
      gap = 0;
      ok = 1'b0;
      cyc(1'b0, 1'b1, s);
      while (s === 1'b1 && gap < 300) begin
         gap++;
         cyc(1'b0, 1'b1, s);
      end
      if (s === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            cyc(1'b0, 1'b1, s);
            d[i] = s;
         end
         cyc(1'b0, 1'b1, p);
         cyc(1'b0, 1'b1, s1);
         cyc(collide, 1'b0, s2);
         ok = (p === ^d) && (s1 === 1'b1) && (s2 === 1'b1);
      end
   endtask : recv
endmodule : prog_link_model
`default_nettype wire

/* tb_top.sv */
// Bench: programmer model on the link, memory responder.
// Assumes the checker is bound in; memory acks one cycle later.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import prog_link_pkg::*;
   localparam logic [7:0] IDENT = 8'hA7; // Arbitrary value.
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_mem_ack = 1'b0;
   logic [7:0]  i_mem_rdata = 8'h00;
   logic        link_clock, prog_drive, prog_val, link_wire;
   logic        o_link_data, o_link_data_oe, o_mem_req, o_mem_write, o_mem_io;
   logic [15:0] o_mem_addr;
   logic [7:0]  o_mem_wdata;
   logic        o_nvm_enable, o_link_error;
   logic [15:0] last_addr;
   logic [7:0]  last_wdata;
   logic        last_write;
   logic        last_io;
   int          req_count = 0;
   int          checks = 0;
   int          miscompares = 0;
   always #2 i_clock = ~i_clock;
   assign link_wire = o_link_data_oe ? o_link_data : (prog_drive ? prog_val : 1'b1);
   prog_link_model prog (.o_link_clock(link_clock), .o_drive(prog_drive), .o_val(prog_val),
      .i_wire(link_wire));
   prog_link_access_layer #(.IDENT_CODE(IDENT)) DUT (.i_clock(i_clock), .i_rst(i_rst),
      .i_link_clock(link_clock), .i_link_data(link_wire), .o_link_data(o_link_data),
      .o_link_data_oe(o_link_data_oe), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
      .o_mem_io(o_mem_io), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
      .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_nvm_enable(o_nvm_enable),
      .o_link_error(o_link_error));
   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hC3;
   endfunction : mem_val
   always @(negedge i_clock) begin
      i_mem_ack <= 1'b0;
      if (o_mem_req === 1'b1) begin
         i_mem_ack <= 1'b1;
         i_mem_rdata <= mem_val(o_mem_addr);
         last_addr <= o_mem_addr;
         last_wdata <= o_mem_wdata;
         last_write <= o_mem_write;
         last_io <= o_mem_io;
         req_count <= req_count + 1;
      end
   end
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic hang(input string what);
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
      close_out();
   endtask : hang
   // Waiting means clocking the link from the model.
   task automatic wait_bit(input logic nvm, input logic exp);
      int n;
      n = 0;
      while (((nvm ? o_nvm_enable : o_link_error) !== exp) && n < 20) begin
         prog.idle(1);
         n++;
      end
      if (n == 20) hang("status never settled");
   endtask : wait_bit
   task automatic rd(input logic [7:0] op, input logic [7:0] exp, input int lo, input int hi);
      logic [7:0] d;
      int         gap;
      logic       ok;
      prog.send_char(op);
      prog.recv(1'b0, d, gap, ok);
      prog.idle(4);
      if (ok !== 1'b1) hang("no well-formed answer");
      check(16'(d), 16'(exp), "read data");
      check(16'(gap >= lo && gap <= hi), 16'h0001, "turnaround idle");
   endtask : rd
   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      prog.send_char(op);
      prog.send_char(d);
      prog.idle(4);
   endtask : wr
   task automatic mem_chk(input int n, input logic [15:0] a, input logic w, input logic io);
      check(16'(req_count), 16'(n + 1), "request count");
      check(last_addr, a, "request address");
      check({14'h0000, last_write, last_io}, {14'h0000, w, io}, "request kind");
   endtask : mem_chk
   task automatic t_reset();
      check({13'h0000, o_link_data, o_link_data_oe, o_mem_req}, 16'h0004, "idle link");
      check({14'h0000, o_nvm_enable, o_link_error}, 16'h0000, "idle status");
   endtask : t_reset
   task automatic t_css();
      rd(8'h8F, IDENT, 130, 140);
      wr(8'hC2, 8'h06);
      rd(8'h82, 8'h06, 4, 14);
      rd(8'h85, 8'h00, 4, 14);
   endtask : t_css
   task automatic t_pointer();
      wr(8'h68, 8'hFF);
      wr(8'h69, 8'h12);
      rd(8'h24, mem_val(16'h12FF), 4, 14);
      mem_chk(0, 16'h12FF, 1'b0, 1'b0);
      wr(8'h60, 8'h3C);
      mem_chk(1, 16'h1300, 1'b1, 1'b0);
      check(16'(last_wdata), 16'h003C, "store data");
      wr(8'h64, 8'h5E);
      mem_chk(2, 16'h1300, 1'b1, 1'b0);
      rd(8'h20, mem_val(16'h1301), 4, 14);
      wr(8'h60, 8'h77);
      mem_chk(4, 16'h1301, 1'b1, 1'b0);
   endtask : t_pointer
   task automatic t_io();
      wr(8'hFF, 8'hA5);
      mem_chk(5, 16'h003F, 1'b1, 1'b1);
      check(16'(last_wdata), 16'h00A5, "io data");
      rd(8'h30, mem_val(16'h0010), 4, 14);
      mem_chk(6, 16'h0010, 1'b0, 1'b1);
   endtask : t_io
   task automatic send_key(input logic [63:0] k);
      prog.send_char(OP_KEY);
      for (int i = 0; i < 8; i++) prog.send_char(k[63 - 8 * i -: 8]);
      prog.idle(6);
   endtask : send_key
   task automatic t_key();
      send_key(64'h1289_AB45_CDD8_88FE);
      check(16'(o_nvm_enable), 16'h0000, "wrong key");
      send_key(NVM_KEY);
      wait_bit(1'b1, 1'b1);
      rd(8'h80, 8'h02, 4, 14);
      wr(8'hC0, 8'h00);
      wait_bit(1'b1, 1'b0);
   endtask : t_key
   task automatic brk();
      prog.send_break();
      wait_bit(1'b0, 1'b0);
   endtask : brk
   task automatic t_errors();
      logic [7:0] d;
      int         gap;
      logic       ok;
      prog.send_bits({2'b11, ~^8'h8F, 8'h8F, 1'b0});
      prog.idle(4);
      wait_bit(1'b0, 1'b1);
      prog.send_char(8'h8F);
      prog.recv(1'b0, d, gap, ok);
      check(16'(ok), 16'h0000, "answer while in error");
      brk();
      prog.send_bits({2'b01, ^8'h8F, 8'h8F, 1'b0});
      prog.idle(4);
      wait_bit(1'b0, 1'b1);
      brk();
      prog.send_char(8'h00);
      prog.idle(4);
      wait_bit(1'b0, 1'b1);
      brk();
      prog.send_char(8'h8F);
      prog.recv(1'b1, d, gap, ok);
      prog.idle(4);
      wait_bit(1'b0, 1'b1);
      brk();
      prog.send_char(8'h60);
      prog.send_break();
      wait_bit(1'b0, 1'b1);
      brk();
      rd(8'h8F, IDENT, 4, 14);
   endtask : t_errors
   initial begin
      fork
         prog.idle(2);
         repeat (6) @(negedge i_clock);
      join
      @(negedge i_clock);
      i_rst = 1'b0;
      #1;
      prog.idle(4);
      t_reset();
      t_css();
      t_pointer();
      t_io();
      t_key();
      t_errors();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
